// ### verilog/pwm_regs.svh
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH

// Register offsets, 8-bit data
`define OFS_MAIN_CTL  4'h0
`define OFS_PERIOD_HI 4'h1
`define OFS_PERIOD_LO 4'h2
`define OFS_CH0_CTL   4'h3
`define OFS_CH0_HI    4'h4
`define OFS_CH0_LO    4'h5
`define OFS_CH1_CTL   4'h6
`define OFS_CH1_HI    4'h7
`define OFS_CH1_LO    4'h8
`define OFS_COUNT_HI  4'h9
`define OFS_COUNT_LO  4'ha

// Main control fields
`define MAIN_OVF_BIT    7
`define MAIN_OVF_IE_BIT 6
`define MAIN_HALT_BIT   5
`define MAIN_CLR_BIT    4
`define MAIN_PS_MSB     2
`define MAIN_PS_EXT     3'h7

// Channel control fields
`define CH_FLAG_BIT  7
`define CH_IE_BIT    6
`define CH_MODE_B    5
`define CH_MODE_A    4
`define CH_ELS_B     3
`define CH_ELS_A     2
`define CH_TOV_BIT   1
`define CH_FULL_BIT  0

// Reset values
`define RST_MAIN_CTL 8'h20
`define RST_PERIOD   16'hffff
`define RST_CH_CTL   8'h00
`define RST_CH_VAL   16'h0000

`endif

// ### verilog/pwm_pkg.sv
package pwm_pkg;
	typedef enum logic [1:0] {
		SEL_CH0 = 2'b01,
		SEL_CH1 = 2'b10
	} sel_e;

	typedef struct packed {
		logic             overflow_flag;
		logic             tof_arm;
		logic             overflow_irq_enable;
		logic             halt;
		logic [2:0]       ps;
		logic             mod_inh;
		logic [15:0]      period;
		logic [7:0]       period_hold;
		logic [15:0]      cnt;
		logic [5:0]       div;
		logic [1:0][7:0]  cctl;
		logic [1:0]       carm;
		logic [1:0][15:0] cval;
		logic [1:0][7:0]  chold;
		sel_e             active;
		sel_e             last;
		logic [1:0]       pin;
		logic [2:0]       sync;
		logic [7:0]       rdata;
	} st_s;
endpackage

// ### verilog/timer_buffered_compare_pwm.sv
// The register offsets and the strobed register port were decided locally.
`include "pwm_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module timer_buffered_compare_pwm
	import pwm_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic [3:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	input  wire logic       i_ext_clk,
	output logic            o_chan0_pin,
	output logic            o_chan0_oe,
	output logic            o_chan1_pin,
	output logic            o_chan1_oe,
	output logic            o_overflow_irq,
	output logic      [1:0] o_chan_irq
);

	st_s q;
	st_s d;

	logic        paired;
	logic        tick;
	logic        ovf_ev;
	logic [1:0]  match;
	logic [1:0]  out_en;
	logic [15:0] cmp0;
	logic [5:0]  ps_mask;

	// Next pin level for one channel on this tick
	function automatic logic chan_next(input logic       pin,
	                                   input logic [7:0] ctl,
	                                   input logic       hit,
	                                   input logic       ovf);
		logic n;
		n = pin;
		if (ctl[`CH_FULL_BIT] && ctl[`CH_TOV_BIT]) begin
			n = ~ctl[`CH_ELS_A];
		end else if (hit) begin
			case (ctl[`CH_ELS_B:`CH_ELS_A])
				2'b01:   n = ~pin;
				2'b10:   n = 1'b0;
				2'b11:   n = 1'b1;
				default: n = pin;
			endcase
		end else if (ovf && ctl[`CH_TOV_BIT]) begin
			n = ~pin;
		end
		return n;
	endfunction

	// Mode pair nonzero means compare/PWM; buffered bit wins
	function automatic logic is_compare(input logic [7:0] ctl);
		return ctl[`CH_MODE_B] || ctl[`CH_MODE_A];
	endfunction

	assign paired  = q.cctl[0][`CH_MODE_B];
	assign ps_mask = 6'((7'h01 << q.ps) - 7'h01);
	assign tick    = !q.halt && ((q.ps == `MAIN_PS_EXT) ?
	                 (q.sync[1] && !q.sync[2]) :
	                 ((q.div & ps_mask) == ps_mask));
	assign ovf_ev  = tick && (q.cnt == q.period);
	assign cmp0    = (paired && q.active == SEL_CH1) ?
	                 q.cval[1] : q.cval[0];
	assign match[0] = tick && is_compare(q.cctl[0]) &&
	                  (q.cnt == cmp0);
	assign match[1] = tick && !paired && is_compare(q.cctl[1]) &&
	                  (q.cnt == q.cval[1]);
	assign out_en[0] = is_compare(q.cctl[0]) &&
	                   (q.cctl[0][`CH_ELS_B:`CH_ELS_A] != 2'b00);
	assign out_en[1] = !paired && is_compare(q.cctl[1]) &&
	                   (q.cctl[1][`CH_ELS_B:`CH_ELS_A] != 2'b00);

	always_comb begin
		d = q;
		d.sync = {q.sync[1:0], i_ext_clk};
		d.rdata = 8'h00;

		// Prescaler and counter
		if (!q.halt && q.ps != `MAIN_PS_EXT) begin
			d.div = q.div + 6'h01;
		end
		if (tick) begin
			d.cnt = ovf_ev ? 16'h0000 : q.cnt + 16'h0001;
		end
		if (ovf_ev && !q.mod_inh) begin
			d.overflow_flag = 1'b1;
		end

		// Channel pins and flags
		for (int i = 0; i < 2; i++) begin
			if (match[i]) begin
				d.cctl[i][`CH_FLAG_BIT] = 1'b1;
			end
		end
		if (out_en[0]) begin
			d.pin[0] = chan_next(q.pin[0], q.cctl[0], match[0], ovf_ev);
		end
		if (out_en[1]) begin
			d.pin[1] = chan_next(q.pin[1], q.cctl[1], match[1], ovf_ev);
		end

		// Buffered hand-over, only at overflow
		if (!paired) begin
			d.active = SEL_CH0;
			d.last   = SEL_CH0;
		end else if (ovf_ev) begin
			d.active = q.last;
		end

		// Register reads
		if (i_rd) begin
			case (i_addr)
				`OFS_MAIN_CTL: begin
					d.rdata = {q.overflow_flag, q.overflow_irq_enable, q.halt, 2'b00, q.ps};
					d.tof_arm = q.overflow_flag;
				end
				`OFS_PERIOD_HI: d.rdata = q.period[15:8];
				`OFS_PERIOD_LO: d.rdata = q.period[7:0];
				`OFS_CH0_CTL: begin
					d.rdata = q.cctl[0];
					d.carm[0] = q.cctl[0][`CH_FLAG_BIT];
				end
				`OFS_CH0_HI: d.rdata = q.cval[0][15:8];
				`OFS_CH0_LO: d.rdata = q.cval[0][7:0];
				`OFS_CH1_CTL: begin
					d.rdata = q.cctl[1];
					d.carm[1] = q.cctl[1][`CH_FLAG_BIT];
				end
				`OFS_CH1_HI: d.rdata = q.cval[1][15:8];
				`OFS_CH1_LO: d.rdata = q.cval[1][7:0];
				`OFS_COUNT_HI: d.rdata = q.cnt[15:8];
				`OFS_COUNT_LO: d.rdata = q.cnt[7:0];
				default: d.rdata = 8'h00;
			endcase
		end

		// Register writes; hardware set beats software clear
		if (i_wr) begin
			case (i_addr)
				`OFS_MAIN_CTL: begin
					if (!i_wdata[`MAIN_OVF_BIT] && q.tof_arm && !ovf_ev) begin
						d.overflow_flag = 1'b0;
					end
					d.tof_arm = 1'b0;
					d.overflow_irq_enable = i_wdata[`MAIN_OVF_IE_BIT];
					d.halt = i_wdata[`MAIN_HALT_BIT];
					d.ps   = i_wdata[`MAIN_PS_MSB:0];
					if (i_wdata[`MAIN_CLR_BIT]) begin
						d.cnt = 16'h0000;
						d.div = 6'h00;
					end
				end
				`OFS_PERIOD_HI: begin
					d.period_hold = i_wdata;
					d.mod_inh = 1'b1;
				end
				`OFS_PERIOD_LO: begin
					d.period = {q.period_hold, i_wdata};
					d.mod_inh = 1'b0;
				end
				`OFS_CH0_HI: d.chold[0] = i_wdata;
				`OFS_CH1_HI: d.chold[1] = i_wdata;
				`OFS_CH0_LO: begin
					d.cval[0] = {q.chold[0], i_wdata};
					if (paired) begin
						d.last = SEL_CH0;
					end
				end
				`OFS_CH1_LO: begin
					d.cval[1] = {q.chold[1], i_wdata};
					if (paired) begin
						d.last = SEL_CH1;
					end
				end
				default: begin
				end
			endcase
			for (int i = 0; i < 2; i++) begin
				if (i_addr == ((i == 0) ? `OFS_CH0_CTL : `OFS_CH1_CTL)) begin
					d.cctl[i][6:0] = i_wdata[6:0];
					if (!i_wdata[`CH_FLAG_BIT] && q.carm[i] && !match[i]) begin
						d.cctl[i][`CH_FLAG_BIT] = 1'b0;
					end
					d.carm[i] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q.overflow_flag         <= 1'b0;
			q.tof_arm     <= 1'b0;
			q.overflow_irq_enable        <= 1'b0;
			q.halt        <= 1'(`RST_MAIN_CTL >> `MAIN_HALT_BIT);
			q.ps          <= 3'h0;
			q.mod_inh     <= 1'b0;
			q.period      <= `RST_PERIOD;
			q.period_hold <= 8'hff;
			q.cnt         <= 16'h0000;
			q.div         <= 6'h00;
			q.cctl        <= {`RST_CH_CTL, `RST_CH_CTL};
			q.carm        <= 2'h0;
			q.cval        <= {`RST_CH_VAL, `RST_CH_VAL};
			q.chold       <= 16'h0000;
			q.active      <= SEL_CH0;
			q.last        <= SEL_CH0;
			q.pin         <= 2'h0;
			q.sync        <= 3'h0;
			q.rdata       <= 8'h00;
		end else begin
			q <= d;
		end
	end

	assign o_rdata        = q.rdata;
	assign o_chan0_pin    = q.pin[0];
	assign o_chan0_oe     = out_en[0];
	assign o_chan1_pin    = q.pin[1];
	assign o_chan1_oe     = out_en[1];
	assign o_overflow_irq = q.overflow_flag && q.overflow_irq_enable;
	assign o_chan_irq[0]  = q.cctl[0][`CH_FLAG_BIT] && q.cctl[0][`CH_IE_BIT];
	assign o_chan_irq[1]  = q.cctl[1][`CH_FLAG_BIT] && q.cctl[1][`CH_IE_BIT];

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_ovf_restart: assert property (
		ovf_ev && !(i_wr && i_addr == `OFS_MAIN_CTL) |=> q.cnt == 16'h0000)
		else $error("counter did not restart after modulo");
	a_ovf_flag: assert property (
		ovf_ev && !q.mod_inh |=> q.overflow_flag)
		else $error("overflow flag not set");
	a_ovf_irq_gate: assert property (
		o_overflow_irq |-> q.overflow_irq_enable && q.overflow_flag)
		else $error("overflow request without enable");
	a_hold_until_ovf: assert property (
		paired && $past(paired) && !ovf_ev |=> $stable(q.active))
		else $error("hand-over outside overflow");
	a_take_last: assert property (
		paired && ovf_ev |=> q.active == $past(q.last))
		else $error("overflow did not pass control to last written");
	a_pair_frees_pin: assert property (
		paired |-> !o_chan1_oe && !match[1])
		else $error("channel 1 still active while paired");
	a_match_flag: assert property (
		match[0] |=> q.cctl[0][`CH_FLAG_BIT])
		else $error("compare did not set channel flag");
	a_clear_on_cmp: assert property (
		match[0] && out_en[0] && !q.cctl[0][`CH_FULL_BIT] &&
		q.cctl[0][`CH_ELS_B:`CH_ELS_A] == 2'b10 |=> !o_chan0_pin)
		else $error("clear-on-compare failed");
	a_no_tov_hold: assert property (
		out_en[0] && ovf_ev && !match[0] && !q.cctl[0][`CH_TOV_BIT]
		|=> $stable(o_chan0_pin))
		else $error("pin toggled at overflow without toggle bit");
	a_full_duty: assert property (
		(out_en[0] && q.cctl[0][`CH_FULL_BIT] && q.cctl[0][`CH_TOV_BIT])
		[*2] |-> o_chan0_pin == !q.cctl[0][`CH_ELS_A])
		else $error("full duty not held");

	c_handover: cover property (paired && ovf_ev && q.last == SEL_CH1);
	c_ch0_clear: cover property (match[0] && out_en[0]);
	c_ovf_irq: cover property (o_overflow_irq);
	c_full_duty: cover property (out_en[0] && q.cctl[0][`CH_FULL_BIT]);

endmodule

`default_nettype wire

// ### sim/timer_buffered_compare_pwm_test.sv
`include "pwm_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module timer_buffered_compare_pwm_test;
	logic       i_clk, i_rst_n, i_wr, i_rd, i_ext_clk, pend, pin_q;
	logic [3:0] i_addr;
	logic [7:0] i_wdata, o_rdata, got, exp_q[$];
	logic       o_chan0_pin, o_chan0_oe, o_chan1_pin, o_chan1_oe;
	logic       o_overflow_irq;
	logic [1:0] o_chan_irq;
	int         n_errors, checks, seed, per, hi, c;

	timer_buffered_compare_pwm u_dut (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_ext_clk(i_ext_clk), .o_chan0_pin(o_chan0_pin),
		.o_chan0_oe(o_chan0_oe), .o_chan1_pin(o_chan1_pin),
		.o_chan1_oe(o_chan1_oe), .o_overflow_irq(o_overflow_irq),
		.o_chan_irq(o_chan_irq)
	);

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	task automatic final_report();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input bit ok, input string msg);
		checks++;
		if (!ok) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	// Read data lands in the cycle after the strobe only
	always @(posedge i_clk) begin
		pin_q <= o_chan0_pin;
		if (pend === 1'b1) begin
			got = exp_q.pop_front();
			chk(o_rdata === got, "read data");
		end
		pend <= i_rd;
	end

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		exp_q.push_back(e);
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask

	// High byte is held until the low byte commits both
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		wr(a, v[15:8]);
		wr(a + 4'h1, v[7:0]);
	endtask

	task automatic setup(input logic [7:0] ctl, input logic [15:0] cmp);
		wr(`OFS_MAIN_CTL, 8'h30);
		wr16(`OFS_PERIOD_HI, 16'h00ff);
		wr16(`OFS_CH0_HI, cmp);
		wr(`OFS_CH0_CTL, ctl);
		wr(`OFS_MAIN_CTL, 8'h00);
	endtask

	task automatic wait_rise();
		int n;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (!(o_chan0_pin === 1'b1 && pin_q === 1'b0) && n < 1200);
		if (n >= 1200) begin
			n_errors++;
			$display("wrong value at %0t: no pin edge", $time);
			final_report();
		end
	endtask

	// Rise to rise: period length and cycles spent high
	task automatic measure();
		wait_rise();
		per = 0;
		hi = 0;
		do begin
			hi += int'(o_chan0_pin === 1'b1);
			per++;
			@(posedge i_clk);
		end while (!(o_chan0_pin === 1'b1 && pin_q === 1'b0) && per < 1200);
	endtask

	// Pulse level lasts from overflow to match, either polarity
	task automatic pwm_check(input int cmp, input bit low_pulse);
		int w;
		measure();
		w = low_pulse ? per - hi : hi;
		chk(per == 256, "pwm period");
		chk(w == cmp || w == cmp + 1, "pulse width");
	endtask

	task automatic hold_check(input logic lvl);
		int n;
		n = 0;
		repeat (300) @(posedge i_clk);
		repeat (300) begin
			@(posedge i_clk);
			n += int'(o_chan0_pin !== lvl);
		end
		chk(n == 0, "steady pin level");
	endtask

	initial begin
		seed = 21;
		i_rst_n = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		i_ext_clk = 1'b0;
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(`OFS_MAIN_CTL, `RST_MAIN_CTL);
		rd(`OFS_PERIOD_HI, 8'hff);
		rd(`OFS_PERIOD_LO, 8'hff);
		rd(`OFS_CH0_CTL, `RST_CH_CTL);
		rd(`OFS_CH1_LO, 8'h00);
		rd(4'hb, 8'h00);
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 3; k++) begin
				c = 1 + ($unsigned($random(seed)) % 254);
				setup(p ? 8'h1e : 8'h1a, 16'(c));
				measure();
				pwm_check(c, p[0]);
			end
		end
		wr16(`OFS_CH0_HI, 16'h0080);
		measure();
		pwm_check(128, 1'b1);
		wr(`OFS_MAIN_CTL, 8'h40);
		repeat (300) @(posedge i_clk);
		rd(`OFS_MAIN_CTL, 8'hc0);
		chk(o_overflow_irq === 1'b1, "overflow irq");
		wr(`OFS_MAIN_CTL, 8'h80);
		repeat (2) @(posedge i_clk);
		chk(o_overflow_irq === 1'b0, "overflow irq masked");
		rd(`OFS_CH0_CTL, 8'h9e);
		chk(o_chan_irq[0] === 1'b0, "channel irq masked");
		wr(`OFS_CH0_CTL, 8'hde);
		repeat (2) @(posedge i_clk);
		chk(o_chan_irq[0] === 1'b1, "channel irq");
		wr(`OFS_CH0_CTL, 8'h98);
		hold_check(1'b0);
		wr(`OFS_CH0_CTL, 8'h9b);
		hold_check(1'b1);
		setup(8'h3a, 16'h0040);
		wr(`OFS_CH1_CTL, 8'h1e);
		pwm_check(64, 1'b0);
		chk(o_chan1_oe === 1'b0 && o_chan0_oe === 1'b1, "pin enables");
		wr16(`OFS_CH1_HI, 16'h00c0);
		pwm_check(192, 1'b0);
		wr16(`OFS_CH0_HI, 16'h0060);
		pwm_check(96, 1'b0);
		wr16(`OFS_CH1_HI, 16'h0090);
		pwm_check(144, 1'b0);
		wr16(`OFS_CH0_HI, 16'h0030);
		pwm_check(48, 1'b0);
		// External clock source counts synchronised rising edges
		wr(`OFS_MAIN_CTL, 8'h37);
		wr(`OFS_MAIN_CTL, 8'h07);
		repeat (5) begin
			repeat (4) @(posedge i_clk);
			i_ext_clk <= 1'b1;
			repeat (4) @(posedge i_clk);
			i_ext_clk <= 1'b0;
		end
		repeat (6) @(posedge i_clk);
		rd(`OFS_COUNT_HI, 8'h00);
		rd(`OFS_COUNT_LO, 8'h05);
		repeat (3) @(posedge i_clk);
		final_report();
	end
endmodule

`default_nettype wire
